//--- rtl/apr_pkg.sv
// constants for the auto-negotiation partner and expansion register bank
package apr_pkg;
  // ------------------------------------------------------------------
  // register map
  // ------------------------------------------------------------------
  localparam logic [4:0]  REG_PARTNER     = 5'h05;
  localparam logic [4:0]  REG_EXPANSION   = 5'h06;
  localparam int          REG_W           = 16;
  localparam logic [15:0] PARTNER_RESET   = 16'h0000;
  localparam logic [15:0] PARTNER_MASK    = 16'he3ff;
  localparam logic [15:0] EXPANSION_RESET = 16'h0000;
  localparam logic [15:0] UNMAPPED_VALUE  = 16'h0000;
  // ------------------------------------------------------------------
  // expansion field positions
  // ------------------------------------------------------------------
  localparam int EXP_AN_ABLE    = 0;
  localparam int EXP_PAGE_RX    = 1;
  localparam int EXP_LOCAL_NP   = 2;
  localparam int EXP_PARTNER_NP = 3;
  localparam int EXP_MULTI_LINK = 4;
  // ------------------------------------------------------------------
  // management frame layout
  // ------------------------------------------------------------------
  localparam logic [5:0] PRE_LEN   = 6'h20;
  localparam logic [1:0] OP_READ   = 2'h2;
  localparam logic [3:0] HDR_LAST  = 4'hb;
  localparam logic [3:0] DATA_LAST = 4'hf;
  localparam logic [3:0] CNT_ZERO  = 4'h0;
  localparam logic [3:0] CNT_ONE   = 4'h1;
  // ------------------------------------------------------------------
  // frame states, one-hot
  // ------------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_PRE = 5'h01,
    ST_SOF = 5'h02,
    ST_HDR = 5'h04,
    ST_TA  = 5'h08,
    ST_DAT = 5'h10
  } apr_state_t;
endpackage

//--- rtl/apr_expansion.sv
// expansion status register with read-to-clear event flags
`timescale 1ns/1ps
`default_nettype none
module apr_expansion
  import apr_pkg::*;
#(
  parameter int N_STICKY = 2
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        soft_rst,
  // events from negotiation logic
  input  wire logic        multi_link_evt,
  input  wire logic        page_rx_evt,
  input  wire logic        partner_np_able,
  input  wire logic        local_np_able,
  input  wire logic        partner_an_able,
  // read side
  input  wire logic        rd_clr,
  output logic [15:0]      exp_word
);
  // ------------------------------------------------------------------
  // sticky flags
  // ------------------------------------------------------------------
  logic [N_STICKY-1:0] evt;
  logic [N_STICKY-1:0] flag;
  assign evt = {multi_link_evt, page_rx_evt};

  genvar gi;
  generate
    for (gi = 0; gi < N_STICKY; gi++) begin : g_flag
      logic next_flag;
      // set wins over the read clear so no event is lost
      assign next_flag = evt[gi] | (flag[gi] & ~rd_clr);
      always_ff @(posedge mclk) begin
        if (!nrst || soft_rst) begin
          flag[gi] <= 1'b0;
        end else begin
          flag[gi] <= next_flag;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // level bits, registered so the read word comes from flops
  // ------------------------------------------------------------------
  logic [2:0] lvl;
  always_ff @(posedge mclk) begin
    if (!nrst || soft_rst) begin
      lvl <= 3'h0;
    end else begin
      lvl <= {partner_np_able, local_np_able, partner_an_able};
    end
  end

  always_comb begin
    exp_word                 = EXPANSION_RESET;
    exp_word[EXP_MULTI_LINK] = flag[1];
    exp_word[EXP_PARTNER_NP] = lvl[2];
    exp_word[EXP_LOCAL_NP]   = lvl[1];
    exp_word[EXP_PAGE_RX]    = flag[0];
    exp_word[EXP_AN_ABLE]    = lvl[0];
  end
endmodule // apr_expansion
`default_nettype wire

//--- rtl/apr_regs.sv
// partner ability and expansion registers behind the management serial port
`timescale 1ns/1ps
`default_nettype none
module apr_regs
  import apr_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        soft_rst,
  // management serial port
  input  wire logic        mdc,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe_n,
  input  wire logic [4:0]  phy_addr,
  // negotiation results
  input  wire logic        base_word_valid,
  input  wire logic [15:0] base_word,
  input  wire logic        multi_link_evt,
  input  wire logic        page_rx_evt,
  input  wire logic        partner_np_able,
  input  wire logic        local_np_able,
  input  wire logic        partner_an_able
);
  // ------------------------------------------------------------------
  // serial clock edge
  // ------------------------------------------------------------------
  logic mdc_q;
  logic mdc_rise;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      mdc_q <= 1'b0;
    end else begin
      mdc_q <= mdc;
    end
  end
  assign mdc_rise = mdc & ~mdc_q;

  // ------------------------------------------------------------------
  // partner ability register
  // ------------------------------------------------------------------
  logic [15:0] partner;
  always_ff @(posedge mclk) begin
    if (!nrst || soft_rst) begin
      partner <= PARTNER_RESET;
    end else if (base_word_valid) begin
      // whole base word kept; reserved 12..10 forced low
      partner <= base_word & PARTNER_MASK;
    end
  end

  // ------------------------------------------------------------------
  // frame engine state
  // ------------------------------------------------------------------
  apr_state_t  state;
  apr_state_t  next_state;
  logic [5:0]  pre_cnt;
  logic [3:0]  bit_cnt;
  logic [11:0] hdr;
  logic [15:0] shadow;
  logic        is_read;
  logic        exp_rd_clr;
  logic [15:0] exp_word;

  // ------------------------------------------------------------------
  // header decode
  // ------------------------------------------------------------------
  wire [11:0] hdr_full  = {hdr[10:0], mdio_in};
  wire        hdr_done  = (state == ST_HDR) && mdc_rise && (bit_cnt == HDR_LAST);
  wire        op_read   = (hdr_full[11:10] == OP_READ);
  wire        addr_hit  = (hdr_full[9:5] == phy_addr);
  wire [4:0]  reg_sel   = hdr_full[4:0];
  wire        rd_take   = hdr_done && op_read && addr_hit;
  wire        sel_part  = (reg_sel == REG_PARTNER);
  wire        sel_exp   = (reg_sel == REG_EXPANSION);
  wire [15:0] rd_value;

  // address decoding
  assign rd_value = sel_part ? partner :
                    sel_exp  ? exp_word : UNMAPPED_VALUE;
  // read of the expansion register clears its event flags
  assign exp_rd_clr = rd_take && sel_exp;

  // ------------------------------------------------------------------
  // frame state machine, advanced on each serial clock rise
  // ------------------------------------------------------------------
  always_comb begin
    next_state = state;
    if (mdc_rise) begin
      case (state)
        ST_PRE: begin
          if (!mdio_in && pre_cnt == PRE_LEN) begin
            next_state = ST_SOF;
          end
        end
        ST_SOF: begin
          next_state = mdio_in ? ST_HDR : ST_PRE;
        end
        ST_HDR: begin
          if (bit_cnt == HDR_LAST) begin
            next_state = ST_TA;
          end
        end
        ST_TA: begin
          if (bit_cnt == CNT_ONE) begin
            next_state = ST_DAT;
          end
        end
        ST_DAT: begin
          if (bit_cnt == DATA_LAST) begin
            next_state = ST_PRE;
          end
        end
        default: next_state = ST_PRE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state <= ST_PRE;
    end else begin
      state <= next_state;
    end
  end

  // preamble: 32 ones needed before each start; a zero early restarts it
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pre_cnt <= 6'h00;
    end else if (mdc_rise) begin
      if (state != ST_PRE || !mdio_in) begin
        pre_cnt <= 6'h00;
      end else if (pre_cnt != PRE_LEN) begin
        pre_cnt <= pre_cnt + 6'h01;
      end
    end
  end

  // bit counter and header shift
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      bit_cnt <= CNT_ZERO;
      hdr     <= 12'h000;
    end else if (mdc_rise) begin
      if (state != next_state) begin
        bit_cnt <= CNT_ZERO;
      end else begin
        bit_cnt <= bit_cnt + CNT_ONE;
      end
      if (state == ST_HDR) begin
        hdr <= hdr_full;
      end
    end
  end

  // ------------------------------------------------------------------
  // read data path: value captured at end of header, shifted msb first
  // ------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      is_read   <= 1'b0;
      shadow    <= 16'h0000;
      mdio_out  <= 1'b1;
      mdio_oe_n <= 1'b1;
    end else if (mdc_rise) begin
      if (hdr_done) begin
        // snapshot so a flag set mid-frame is seen next read, not lost
        is_read <= rd_take;
        shadow  <= rd_value;
      end else if (state == ST_TA && is_read && bit_cnt == CNT_ZERO) begin
        // first turnaround bit left to float, second driven low
        mdio_oe_n <= 1'b0;
        mdio_out  <= 1'b0;
      end else if (state == ST_TA && is_read) begin
        mdio_out <= shadow[15];
        shadow   <= {shadow[14:0], 1'b0};
      end else if (state == ST_DAT && is_read && bit_cnt != DATA_LAST) begin
        mdio_out <= shadow[15];
        shadow   <= {shadow[14:0], 1'b0};
      end else if (state == ST_DAT) begin
        // writes are accepted in form only; all bits here are read-only
        is_read   <= 1'b0;
        mdio_oe_n <= 1'b1;
        mdio_out  <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // expansion register
  // ------------------------------------------------------------------
  apr_expansion #(
    .N_STICKY (2)
  ) u_exp (
    .mclk            (mclk),
    .nrst            (nrst),
    .soft_rst        (soft_rst),
    .multi_link_evt  (multi_link_evt),
    .page_rx_evt     (page_rx_evt),
    .partner_np_able (partner_np_able),
    .local_np_able   (local_np_able),
    .partner_an_able (partner_an_able),
    .rd_clr          (exp_rd_clr),
    .exp_word        (exp_word)
  );
endmodule // apr_regs
`default_nettype wire

//--- bench/apr_regs_chk.sv
// port assertions for the partner and expansion register bank
`timescale 1ns/1ps
`default_nettype none
module apr_regs_chk (
  // watched ports
  input wire logic mclk,
  input wire logic nrst,
  input wire logic soft_rst,
  input wire logic mdc,
  input wire logic mdio_out,
  input wire logic mdio_oe_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // ------------------------------------------------------------------
  // mdc rises counted while the device drives
  // ------------------------------------------------------------------
  logic       mdc_q;
  logic [4:0] rises;
  always_ff @(posedge mclk) begin
    mdc_q <= mdc;
    if (!nrst || mdio_oe_n) rises <= 5'h00;
    else if (mdc && !mdc_q) rises <= rises + 5'h01;
  end
  idle_level_a: assert property (mdio_oe_n |-> mdio_out)
    else $error("data line low while released");
  reset_idle_a: assert property ($rose(nrst) |-> mdio_oe_n && mdio_out)
    else $error("port not idle after reset");
  on_rise_a: assert property ($changed(mdio_out) || $changed(mdio_oe_n) |-> $past(mdc))
    else $error("port changed away from an mdc rise");
  ta_zero_a: assert property ($fell(mdio_oe_n) |-> !mdio_out)
    else $error("turnaround bit not zero");
  drive_span_a: assert property ($rose(mdio_oe_n) |-> rises == 5'h11)
    else $error("drive window not seventeen mdc rises");
  drive_min_a: assert property ($fell(mdio_oe_n) |-> !mdio_oe_n [*8])
    else $error("drive window too short");
  soft_keep_a: assert property (soft_rst && !mdio_oe_n && !mdc && !$past(mdc) |=> !mdio_oe_n)
    else $error("register reset aborted a frame");
  bit_hold_a: assert property (!mdio_oe_n && !mdc && !$past(mdc) |=> $stable(mdio_out))
    else $error("data bit moved while mdc low");
endmodule // apr_regs_chk
bind apr_regs apr_regs_chk u_chk (.mclk(mclk), .nrst(nrst), .soft_rst(soft_rst), .mdc(mdc),
  .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n));
`default_nettype wire

//--- bench/apr_station.sv
// management station model on the serial port
`timescale 1ns/1ps
`default_nettype none
module apr_station (
  // clock
  input  wire logic mclk,
  // device side
  input  wire logic mdio_out,
  input  wire logic mdio_oe_n,
  // line side
  output logic      mdc,
  output logic      mdio_wire
);
  logic dr_en;
  logic dr_bit;
  // pull-up: a released line reads high
  assign mdio_wire = !mdio_oe_n ? mdio_out : (dr_en ? dr_bit : 1'b1);
  initial begin
    mdc = 1'b0;
    dr_en = 1'b0;
    dr_bit = 1'b1;
  end
  // four mclk per bit; sampling just before the rise catches the settled bit
  task automatic bit_cyc(input logic en, input logic b, output logic s);
    repeat (2) @(posedge mclk);
    #1 mdc = 1'b0;
    dr_en = en;
    dr_bit = b;
    repeat (2) @(posedge mclk);
    #1 s = mdio_wire;
    mdc = 1'b1;
  endtask
  // preamble, start, header, turnaround, 16 data bits msb first
  task automatic xfer(input int pre, input logic [1:0] op, input logic [4:0] phy,
                      input logic [4:0] ra, output logic [15:0] d, output logic drove);
    logic [13:0] hdr;
    logic        s;
    hdr = {2'h1, op, phy, ra};
    for (int i = 0; i < pre; i++) bit_cyc(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) bit_cyc(1'b1, hdr[i], s);
    bit_cyc(1'b0, 1'b1, s);
    bit_cyc(1'b0, 1'b1, s);
    drove = !s;
    for (int i = 15; i >= 0; i--) bit_cyc(1'b0, 1'b1, d[i]);
    repeat (2) @(posedge mclk);
    #1 mdc = 1'b0;
  endtask
endmodule // apr_station
`default_nettype wire

//--- bench/apr_regs_tb_top.sv
// self-checking bench for the partner and expansion register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
module apr_regs_tb_top import apr_pkg::*; ();
  localparam logic [4:0] PHY = 5'h0b;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic        soft_rst = 1'b0;
  logic        bw_valid = 1'b0;
  logic [15:0] bw = 16'h0000;
  logic [4:0]  ev = 5'h00;
  logic [15:0] d;
  logic        drv;
  wire         mdc, mdio_wire, mdio_out, mdio_oe_n;
  int          mismatches = 0;
  int          comparisons = 0;
  int          cycles = 0;
  always #20 mclk = ~mclk;
  apr_regs dut (.mclk(mclk), .nrst(nrst), .soft_rst(soft_rst), .mdc(mdc), .mdio_in(mdio_wire),
    .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .phy_addr(PHY), .base_word_valid(bw_valid),
    .base_word(bw), .multi_link_evt(ev[4]), .page_rx_evt(ev[1]), .partner_np_able(ev[3]),
    .local_np_able(ev[2]), .partner_an_able(ev[0]));
  apr_station st (.mclk(mclk), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .mdc(mdc),
    .mdio_wire(mdio_wire));
  // about 7000 cycles expected; hang guard well above
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic rd(input logic [4:0] ra, input logic [15:0] e);
    st.xfer(32, OP_READ, PHY, ra, d, drv);
    `CHK("drive", 1'b1, drv)
    `CHK("read data", e, d)
  endtask
  task automatic load(input logic [15:0] w);
    @(posedge mclk);
    #1 bw = w;
    bw_valid = 1'b1;
    @(posedge mclk);
    #1 bw_valid = 1'b0;
  endtask
  initial begin
    static logic [15:0] w_t[2] = '{16'hffff, 16'h4a21};
    static logic [4:0]  un_t[3] = '{5'h00, 5'h07, 5'h1f};
    static int          pre_t[4] = '{32, 32, 31, 40};
    static logic [1:0]  op_t[4] = '{2'h1, 2'h2, 2'h2, 2'h2};
    static logic [4:0]  phy_t[4] = '{5'h0b, 5'h0a, 5'h0b, 5'h0b};
    static logic        dr_t[4] = '{1'b0, 1'b0, 1'b0, 1'b1};
    repeat (5) @(posedge mclk);
    #1 nrst = 1'b1;
    rd(REG_PARTNER, 16'h0000);
    rd(REG_EXPANSION, 16'h0000);
    foreach (w_t[i]) begin
      load(w_t[i]);
      rd(REG_PARTNER, w_t[i] & 16'he3ff);
    end
    // flags latch and clear on read; levels follow
    for (int i = 0; i < 5; i++) begin
      @(posedge mclk);
      #1 ev[i] = 1'b1;
      @(posedge mclk);
      #1 ev[i] = !(i == 1 || i == 4);
      rd(REG_EXPANSION, 16'h0001 << i);
      rd(REG_EXPANSION, (i == 1 || i == 4) ? 16'h0000 : 16'h0001 << i);
      @(posedge mclk);
      #1 ev[i] = 1'b0;
    end
    // event on the clearing edge must survive; that read shows the older snapshot
    fork
      rd(REG_EXPANSION, 16'h0000);
      begin
        repeat (184) @(posedge mclk);
        #1 ev[4] = 1'b1;
        @(posedge mclk);
        #1 ev[4] = 1'b0;
      end
    join
    rd(REG_EXPANSION, 16'h0010);
    rd(REG_EXPANSION, 16'h0000);
    foreach (un_t[i]) rd(un_t[i], 16'h0000);
    // write op, wrong address, short and long preamble
    foreach (pre_t[i]) begin
      st.xfer(pre_t[i], op_t[i], phy_t[i], REG_EXPANSION, d, drv);
      `CHK("drive", dr_t[i], drv)
    end
    load(16'hffff);
    @(posedge mclk);
    #1 ev[1] = 1'b1;
    @(posedge mclk);
    #1 ev[1] = 1'b0;
    fork
      rd(REG_PARTNER, 16'he3ff);
      begin
        repeat (200) @(posedge mclk);
        #1 soft_rst = 1'b1;
        repeat (4) @(posedge mclk);
        #1 soft_rst = 1'b0;
      end
    join
    rd(REG_EXPANSION, 16'h0000);
    rd(REG_PARTNER, 16'h0000);
    tally_and_finish();
  end
endmodule // apr_regs_tb_top
`default_nettype wire
